/* File: include/span_scale_cfg.svh */
/*
 Constants for the bridge span, offset and scale arithmetic.
 Assumes inclusion by the package, the core modules and the bench checker.
*/
// How it works
// [RULE1] Resistor-span mode scales measured compensation resistor by span gain of its bridge
// [RULE2] Span gains live in register 14 (first) and register 15 (second)
// [RULE3] Single fullbridge uses first gain; doublebridge uses first then second gain
// [RULE4] Span gain is unsigned 24 bits, 8 integer and 16 fraction bits
// [RULE5] Zero span gain removes compensation resistor, so no span correction
// [RULE6] With both span modes set, temperature ratio drives span; bridge resistor ignored
// [RULE7] Temperature span: result times one plus or minus gain times temperature ratio
// [RULE8] Two sign bits in register 10 choose add or subtract of span term
// [RULE9] Resistor mode without temperature run writes (Rcomp+Rsg)/Rsg to temperature result
// [RULE10] Software sets span gains near 0.75 for existing Wheatstone bridges
// [RULE11] Software captures offset with zero gain, half scales, offset subtraction off
// [RULE12] Offset is signed, 16 integer and 8 fraction bits
// [RULE13] Two scale factors, unsigned 24 bits, 8 integer and 16 fraction bits
// [RULE14] Register 0 bit 17 enables first scale; register 8 bit 0 enables second
// [RULE15] Single bridge: first scale on halfbridge one, second on halfbridge two
// [RULE16] Halfbridge scales apply before sum or difference combining
// [RULE17] Doublebridge: first scale on fullbridge one, second on fullbridge two
// [RULE18] Doublebridge uncombined halves both use their fullbridge's scale
// [RULE19] Span and offset act only in fullbridge modes; each fullbridge its own
// [RULE20] Offset subtracted only when enabled, before scaling, in wide signed arithmetic
// [RULE21] Products drop 16 fraction bits so a factor of one is exact
`ifndef SPAN_SCALE_CFG_SVH
`define SPAN_SCALE_CFG_SVH
`define RES_W 24
`define COEF_W 24
`define FRAC_W 16
`define OFFS_FRAC_W 8
`define WIDE_W 56
`define REG_SPAN_GAIN_FIRST 14
`define REG_SPAN_GAIN_SECOND 15
`define REG_SPAN_SIGN 10
`define REG_SCALE_FIRST_EN 0
`define BIT_SCALE_FIRST_EN 17
`define REG_SCALE_SECOND_EN 8
`define BIT_SCALE_SECOND_EN 0
`define ONE_FIXED 24'h010000
`endif

/* File: include/span_scale_pkg.sv */
/*
 Types for the bridge span, offset and scale arithmetic.
 Assumes the cfg header is on the include path.
*/
`include "span_scale_cfg.svh"
package span_scale_pkg;
  typedef logic signed [`RES_W-1:0] result_t;
  typedef logic [`COEF_W-1:0] coef_t;
  typedef logic signed [`WIDE_W-1:0] wide_t;
  typedef enum logic [1:0] {
    BRIDGE_HALF = 2'b00,
    BRIDGE_FULL = 2'b01,
    BRIDGE_DOUBLE = 2'b10
  } bridge_mode_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SPAN = 4'b0010,
    ST_SCALE = 4'b0100,
    ST_DONE = 4'b1000
  } state_t;
endpackage

/* File: core/fixed_mul.sv */
/*
 Signed value times unsigned 8.16 coefficient, fraction dropped and truncated to the wide width.
 Assumes combinational use inside the core clock domain.
*/
`timescale 1ns/100ps
`include "span_scale_cfg.svh"
module fixed_mul (
  input wire logic signed [`WIDE_W-1:0] value,
  input wire logic [`COEF_W-1:0] coef,
  output logic signed [`WIDE_W-1:0] product
);
  logic signed [`WIDE_W+`COEF_W:0] full;
  always_comb begin
    full = value * $signed({1'b0, coef});
    product = `WIDE_W'(full >>> `FRAC_W); // [RULE21]
  end
endmodule

/* File: core/bridge_span_offset_scaling.sv */
/*
 Post-conversion arithmetic: span compensation, offset removal, scale factors.
 Assumes raw ppm results and ratios arrive from the conversion engine on clock,
 with start a one-cycle pulse; coefficients are held steady by the register file.
*/
`timescale 1ns/100ps
`include "span_scale_cfg.svh"
module bridge_span_offset_scaling (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic start,
  input wire span_scale_pkg::bridge_mode_t bridge_mode,
  input wire logic halfbridge_sum_combine,
  input wire logic halfbridge_diff_combine,
  input wire logic span_resistor_mode,
  input wire logic span_from_temperature,
  input wire logic temp_measure_active,
  input wire logic [`COEF_W-1:0] span_gain_first,
  input wire logic [`COEF_W-1:0] span_gain_second,
  input wire logic span_sign_first,
  input wire logic span_sign_second,
  input wire logic signed [`RES_W-1:0] bridge_offset_first,
  input wire logic signed [`RES_W-1:0] bridge_offset_second,
  input wire logic offset_subtract_enable,
  input wire logic [`COEF_W-1:0] scale_factor_first,
  input wire logic [`COEF_W-1:0] scale_factor_second,
  input wire logic scale_first_enable,
  input wire logic scale_second_enable,
  input wire logic signed [`RES_W-1:0] half_raw_0,
  input wire logic signed [`RES_W-1:0] half_raw_1,
  input wire logic signed [`RES_W-1:0] half_raw_2,
  input wire logic signed [`RES_W-1:0] half_raw_3,
  input wire logic [`COEF_W-1:0] comp_ratio_first,
  input wire logic [`COEF_W-1:0] comp_ratio_second,
  input wire logic [`COEF_W-1:0] temp_ratio,
  output logic signed [`RES_W-1:0] result_0,
  output logic signed [`RES_W-1:0] result_1,
  output logic signed [`RES_W-1:0] result_2,
  output logic signed [`RES_W-1:0] result_3,
  output logic [`COEF_W-1:0] temperature_result,
  output logic temperature_valid,
  output logic busy,
  output logic done
);
  import span_scale_pkg::*;

  // Saturation bounds of the 24-bit result word
  localparam logic signed [`WIDE_W-1:0] MAX_RES = `WIDE_W'(24'sh7fffff);
  localparam logic signed [`WIDE_W-1:0] MIN_RES = `WIDE_W'(24'sh800000);

  state_t state_reg, state_next;
  wide_t work_reg [4];
  logic signed [`RES_W-1:0] raw [4];
  logic signed [`RES_W-1:0] out_reg [4];
  logic [`COEF_W-1:0] temp_reg;
  logic temp_valid_reg;
  logic done_reg;

  logic is_full, is_double, combine;
  logic [`COEF_W-1:0] span_factor [2];
  wide_t span_prod [4];
  wide_t scale_prod [4];
  logic [`COEF_W-1:0] span_term [2];
  wide_t gain_term [2];
  logic [`COEF_W-1:0] scale_coef [4];
  logic scale_en [4];

  assign raw[0] = half_raw_0;
  assign raw[1] = half_raw_1;
  assign raw[2] = half_raw_2;
  assign raw[3] = half_raw_3;
  assign is_full = (bridge_mode == BRIDGE_FULL);
  assign is_double = (bridge_mode == BRIDGE_DOUBLE);
  assign combine = halfbridge_sum_combine | halfbridge_diff_combine;

  // Span factor per fullbridge, gain terms from both sources
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_span
      logic [`COEF_W-1:0] gain;
      logic sign_neg;
      logic [`COEF_W-1:0] ratio;
      assign gain = (g == 0) ? span_gain_first : span_gain_second; // [RULE2] [RULE3]
      assign sign_neg = (g == 0) ? span_sign_first : span_sign_second;
      assign ratio = (span_from_temperature) ? temp_ratio : // [RULE6]
        ((g == 0) ? comp_ratio_first : comp_ratio_second);
      fixed_mul u_gain (
        .value(`WIDE_W'(signed'({1'b0, ratio}))),
        .coef(gain),
        .product(gain_term[g])
      ); // [RULE1] [RULE4] [RULE7]
      always_comb begin
        // Zero gain gives zero term, leaving factor of exactly one
        span_term[g] = `COEF_W'(gain_term[g]); // [RULE5]
        if (!span_resistor_mode) begin
          span_factor[g] = `ONE_FIXED;
        end else if (sign_neg) begin
          span_factor[g] = `ONE_FIXED - span_term[g]; // [RULE8]
        end else begin
          span_factor[g] = `ONE_FIXED + span_term[g]; // [RULE8]
        end
      end
    end
  endgenerate

  // Per channel span then scale multipliers
  generate
    for (g = 0; g < 4; g++) begin : g_chan
      logic [`COEF_W-1:0] sfac;
      assign sfac = (is_double && g >= 2) ? span_factor[1] : span_factor[0]; // [RULE3]
      fixed_mul u_span (
        .value(work_reg[g]),
        .coef(sfac),
        .product(span_prod[g])
      );
      always_comb begin
        if (is_double) begin
          // Each fullbridge scale covers both halves when not combined
          scale_coef[g] = (g >= 2) ? scale_factor_second : scale_factor_first; // [RULE17] [RULE18]
          scale_en[g] = (g >= 2) ? scale_second_enable : scale_first_enable;
        end else begin
          scale_coef[g] = (g % 2 == 1) ? scale_factor_second : scale_factor_first; // [RULE15]
          scale_en[g] = (g % 2 == 1) ? scale_second_enable : scale_first_enable; // [RULE14]
        end
      end
      fixed_mul u_scale (
        .value(work_reg[g]),
        .coef(scale_coef[g]),
        .product(scale_prod[g])
      ); // [RULE13] [RULE16]
    end
  endgenerate

  // Clamp a wide working value to the result word
  function automatic logic signed [`RES_W-1:0] sat(input wide_t v);
    logic signed [`RES_W-1:0] r;
    r = `RES_W'(v);
    if (v > MAX_RES) begin
      r = 24'sh7fffff;
    end else if (v < MIN_RES) begin
      r = 24'sh800000;
    end
    return r;
  endfunction

  // Offset in whole ppm, fraction bits dropped
  function automatic wide_t offset_fix(input logic signed [`RES_W-1:0] off);
    wide_t w;
    w = `WIDE_W'(off) >>> `OFFS_FRAC_W; // [RULE12]
    return w;
  endfunction

  // Sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_SPAN;
        end
      end
      ST_SPAN: begin
        state_next = ST_SCALE;
      end
      ST_SCALE: begin
        state_next = ST_DONE;
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Working values: load, span and offset, scale
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 4; i++) begin
        work_reg[i] <= '0;
      end
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            for (int i = 0; i < 4; i++) begin
              work_reg[i] <= `WIDE_W'(raw[i]);
            end
          end
        end
        ST_SPAN: begin
          // Halfbridge modes bypass span and offset
          if (is_full || is_double) begin // [RULE19]
            for (int i = 0; i < 4; i++) begin
              if (offset_subtract_enable) begin // [RULE20]
                work_reg[i] <= span_prod[i] -
                  offset_fix((is_double && i >= 2) ? bridge_offset_second : bridge_offset_first);
              end else begin
                work_reg[i] <= span_prod[i];
              end
            end
          end
        end
        ST_SCALE: begin
          for (int i = 0; i < 4; i++) begin
            if (scale_en[i]) begin
              work_reg[i] <= scale_prod[i]; // [RULE14] [RULE16]
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Output registers, combining halves after scaling
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 4; i++) begin
        out_reg[i] <= '0;
      end
    end else if (state_reg == ST_DONE) begin
      for (int i = 0; i < 4; i += 2) begin
        if (bridge_mode != BRIDGE_HALF && combine) begin // [RULE16]
          out_reg[i] <= sat(halfbridge_diff_combine ? work_reg[i] - work_reg[i+1] :
            work_reg[i] + work_reg[i+1]);
          out_reg[i+1] <= '0;
        end else begin
          out_reg[i] <= sat(work_reg[i]);
          out_reg[i+1] <= sat(work_reg[i+1]);
        end
      end
    end
  end

  // Temperature register from compensation resistor ratio
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      temp_reg <= '0;
      temp_valid_reg <= 1'b0;
    end else if (state_reg == ST_DONE) begin
      if (span_resistor_mode && !span_from_temperature && !temp_measure_active) begin
        temp_reg <= comp_ratio_first; // [RULE9]
        temp_valid_reg <= 1'b1;
      end else begin
        temp_valid_reg <= 1'b0;
      end
    end else begin
      temp_valid_reg <= 1'b0;
    end
  end

  // Done pulse registered on the same edge as the output write
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (state_reg == ST_DONE);
    end
  end

  assign result_0 = out_reg[0];
  assign result_1 = out_reg[1];
  assign result_2 = out_reg[2];
  assign result_3 = out_reg[3];
  assign temperature_result = temp_reg;
  assign temperature_valid = temp_valid_reg;
  assign busy = (state_reg != ST_IDLE);
  assign done = done_reg;
endmodule

/* File: bench/span_scale_asserts.sv */
/* Checker for the span, offset and scale block.
   Sees only top-level ports; bound in by the bench. */
`timescale 1ns/100ps
`include "span_scale_cfg.svh"
module span_scale_asserts (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic start,
  input wire logic busy,
  input wire logic done,
  input wire logic temperature_valid,
  input wire span_scale_pkg::bridge_mode_t bridge_mode,
  input wire logic span_resistor_mode,
  input wire logic span_from_temperature,
  input wire logic temp_measure_active,
  input wire logic scale_first_enable,
  input wire logic [`COEF_W-1:0] scale_factor_first,
  input wire logic signed [`RES_W-1:0] half_raw_0,
  input wire logic signed [`RES_W-1:0] result_0
);
  import span_scale_pkg::*;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  wire logic half_done = done && bridge_mode == BRIDGE_HALF;
  a_done_after_start: assert property (start && !busy |-> ##[3:5] done)
    else $error("done missing after start");
  a_busy_after_start: assert property (start && !busy |=> busy)
    else $error("busy missing after start");
  a_busy_holds_done: assert property (busy |=> busy || done)
    else $error("busy dropped without done");
  a_done_one_cycle: assert property (done |=> !done) else $error("done too long");
  a_done_not_busy: assert property (done |-> !busy) else $error("busy during done");
  a_valid_with_done: assert property (temperature_valid |-> done)
    else $error("valid without done");
  a_temp_ratio_store: assert property (
    done && bridge_mode != BRIDGE_HALF && span_resistor_mode && !span_from_temperature
    && !temp_measure_active |-> temperature_valid) else $error("temperature not stored");
  a_half_no_comp: assert property (
    half_done && !scale_first_enable |-> result_0 == half_raw_0) else $error("half altered");
  a_unity_scale: assert property (
    half_done && scale_first_enable && scale_factor_first == `ONE_FIXED
    |-> result_0 == half_raw_0) else $error("unity scale changed value");
  c_double: cover property (done && bridge_mode == BRIDGE_DOUBLE);
  c_temp: cover property (done && span_from_temperature);
  c_half: cover property (half_done && scale_first_enable);
endmodule

/* File: bench/test_bridge_span_offset_scaling.sv */
/* Self-checking bench for the span, offset and scale block.
   Drives every port directly; the checker is bound at the foot. */
`timescale 1ns/100ps
module test_bridge_span_offset_scaling;
  import span_scale_pkg::*;
  localparam coef_t f1 = 24'h010000;
  localparam coef_t f2 = 24'h020000;
  localparam coef_t fh = 24'h008000;
  localparam coef_t fq = 24'h004000;
  logic clock, rst_b, start, halfbridge_sum_combine, halfbridge_diff_combine;
  logic span_resistor_mode, span_from_temperature, temp_measure_active;
  logic span_sign_first, span_sign_second, offset_subtract_enable;
  logic scale_first_enable, scale_second_enable, temperature_valid, busy, done;
  bridge_mode_t bridge_mode;
  coef_t span_gain_first, span_gain_second, scale_factor_first, scale_factor_second;
  coef_t comp_ratio_first, comp_ratio_second, temp_ratio, temperature_result;
  result_t bridge_offset_first, bridge_offset_second, half_raw_0, half_raw_1;
  result_t half_raw_2, half_raw_3, result_0, result_1, result_2, result_3;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;
  bridge_span_offset_scaling i_bridge_span_offset_scaling (.*);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      conclude;
    end
  end
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] e);
    num_checks++;
    if (seen !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, seen);
    end
  endtask
  task automatic chk4(input result_t e0, e1, e2, e3);
    chk("r0", result_0, e0);
    chk("r1", result_1, e1);
    chk("r2", result_2, e2);
    chk("r3", result_3, e3);
  endtask
  // Neutral settings: full mode, every correction off
  task automatic base;
    bridge_mode <= BRIDGE_FULL;
    {halfbridge_sum_combine, halfbridge_diff_combine, span_resistor_mode,
      span_from_temperature, temp_measure_active, span_sign_first, span_sign_second,
      offset_subtract_enable, scale_first_enable, scale_second_enable} <= '0;
    {span_gain_first, span_gain_second, comp_ratio_first, comp_ratio_second, temp_ratio} <= '0;
    {bridge_offset_first, bridge_offset_second, half_raw_0, half_raw_1, half_raw_2,
      half_raw_3} <= '0;
    {scale_factor_first, scale_factor_second} <= {f1, f1};
  endtask
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (done !== 1'b1 && n < 10);
    chk("done", done, 1'b1);
  endtask
  task automatic run;
    int n;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    wait_done(n);
    chk("latency", 24'(n), 24'h000003);
  endtask
  task automatic t_half;
    @(posedge clock);
    base;
    bridge_mode <= BRIDGE_HALF;
    {span_resistor_mode, offset_subtract_enable, scale_second_enable} <= 3'h7;
    {span_gain_first, comp_ratio_first, bridge_offset_first} <= {fh, f1, 24'h000a00};
    {half_raw_0, half_raw_1} <= {24'h000064, 24'hffffd8};
    {half_raw_2, half_raw_3, scale_factor_second} <= {24'h00012c, 24'hfffff8, fh};
    run;
    chk4(24'h000064, 24'hffffec, 24'h00012c, 24'hfffffc);
    @(posedge clock);
    {scale_first_enable, scale_second_enable, scale_factor_first} <= {2'h2, f2};
    run;
    chk4(24'h0000c8, 24'hffffd8, 24'h000258, 24'hfffff8);
    @(posedge clock);
    scale_factor_first <= f1;
    run;
    chk("unity", result_0, 24'h000064);
  endtask
  task automatic t_combine;
    for (int i = 1; i < 4; i++) begin
      @(posedge clock);
      base;
      {half_raw_0, half_raw_1} <= {24'h000064, 24'h000028};
      {scale_factor_first, scale_factor_second, scale_first_enable, scale_second_enable}
        <= {f2, fh, 2'h3};
      {halfbridge_sum_combine, halfbridge_diff_combine} <= i[1:0];
      run;
      chk("comb", result_0, (i == 2) ? 24'h0000dc : 24'h0000b4);
      chk("spare", result_1, 24'h000000);
    end
  endtask
  task automatic t_double;
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      base;
      bridge_mode <= BRIDGE_DOUBLE;
      {half_raw_0, half_raw_1} <= {24'h00000a, 24'h000014};
      {half_raw_2, half_raw_3} <= {24'h00001e, 24'h000028};
      {scale_factor_first, scale_factor_second} <= {f2, fh};
      {scale_first_enable, scale_second_enable, halfbridge_sum_combine} <= {2'h3, i[0]};
      run;
      if (i == 0) chk4(24'h000014, 24'h000028, 24'h00000f, 24'h000014);
      else chk4(24'h00003c, 24'h000000, 24'h000023, 24'h000000);
    end
  endtask
  task automatic t_span_res;
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      base;
      {span_resistor_mode, span_sign_first} <= {1'b1, i[0]};
      {comp_ratio_first, half_raw_0} <= {f1, 24'h0003e8};
      span_gain_first <= (i == 2) ? 24'h000000 : fh;
      run;
      chk("span", result_0, i[1] ? 24'h0003e8 : i[0] ? 24'h0001f4 : 24'h0005dc);
      chk("temp", temperature_result, f1);
      chk("tvalid", temperature_valid, 1'b1);
    end
    @(posedge clock);
    base;
    bridge_mode <= BRIDGE_DOUBLE;
    {span_resistor_mode, span_sign_second} <= 2'h3;
    {span_gain_first, span_gain_second, comp_ratio_first, comp_ratio_second} <= {fh, fq, f1, f2};
    {half_raw_0, half_raw_2} <= {24'h0003e8, 24'h0003e8};
    run;
    chk("span1", result_0, 24'h0005dc);
    chk("span2", result_2, 24'h0001f4);
  endtask
  task automatic t_span_temp;
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      base;
      {span_resistor_mode, span_from_temperature, temp_measure_active} <= 3'h7;
      {span_gain_first, temp_ratio, comp_ratio_first, half_raw_0} <= {fq, f1, f2, 24'h0003e8};
      span_sign_first <= i[0];
      run;
      chk("tspan", result_0, i ? 24'h0002ee : 24'h0004e2);
      chk("tvalid off", temperature_valid, 1'b0);
    end
  endtask
  task automatic offs(input result_t off, input logic en, input coef_t sf, input result_t e);
    @(posedge clock);
    base;
    {bridge_offset_first, offset_subtract_enable, half_raw_0} <= {off, en, 24'h0003e8};
    {scale_factor_first, scale_first_enable} <= {sf, 1'b1};
    run;
    chk("offset", result_0, e);
  endtask
  // Software flows: offset capture, then Wheatstone span gains
  task automatic t_soft;
    @(posedge clock);
    base;
    {span_resistor_mode, comp_ratio_first, half_raw_0} <= {1'b1, f1, 24'h0003e8};
    {scale_factor_second, scale_first_enable, scale_second_enable} <= {fh, 2'h3};
    scale_factor_first <= fh;
    run;
    chk("capture", result_0, 24'h0001f4);
    @(posedge clock);
    {bridge_offset_first, offset_subtract_enable} <= {result_0[15:0], 8'h00, 1'b1};
    run;
    chk("captured", result_0, 24'h0000fa);
    @(posedge clock);
    base;
    {span_resistor_mode, comp_ratio_first, half_raw_0} <= {1'b1, f1, 24'h0003e8};
    {span_gain_first, span_gain_second} <= {24'h00c000, 24'h00c000};
    run;
    chk("wheatstone", result_0, 24'h0006d6);
  endtask
  task automatic t_refuse;
    int n;
    @(posedge clock);
    base;
    {half_raw_0, scale_factor_first, scale_first_enable} <= {24'h000064, f2, 1'b1};
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    @(posedge clock);
    {start, half_raw_0} <= {1'b1, 24'h000007};
    #1;
    chk("busy", busy, 1'b1);
    @(posedge clock);
    start <= 1'b0;
    wait_done(n);
    chk("refused", result_0, 24'h0000c8);
    repeat (6) begin
      @(posedge clock);
      #1;
      chk("one done", done, 1'b0);
    end
  endtask
  initial begin
    rst_b = 1'b0;
    start = 1'b0;
    base;
    repeat (16) @(posedge clock);
    #1;
    chk4('0, '0, '0, '0);
    chk("rst done", done, 1'b0);
    @(posedge clock);
    rst_b <= 1'b1;
    t_half;
    t_combine;
    t_double;
    t_span_res;
    t_span_temp;
    offs(24'h000a80, 1'b1, f1, 24'h0003de);
    offs(24'hfff400, 1'b1, f1, 24'h0003f4);
    offs(24'h000a00, 1'b1, f2, 24'h0007bc);
    offs(24'h000a00, 1'b0, f1, 24'h0003e8);
    t_soft;
    t_refuse;
    conclude;
  end
endmodule
bind bridge_span_offset_scaling span_scale_asserts i_span_scale_asserts (.*);
